//--- logic/tmrc_pkg.sv
// package of constants for the timer/counter with prescaler
package tmrc_pkg;
  localparam int          CNT_W        = 8;
  localparam int          PS_W         = 8;
  localparam int          SEL_W        = 3;
  localparam int          OPT_CS_BIT   = 5;
  localparam int          OPT_SE_BIT   = 4;
  localparam int          OPT_PSA_BIT  = 3;
  localparam int          INTC_IF_BIT  = 2;
  localparam int          INTC_IE_BIT  = 5;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  PS_RST       = 8'h00;
  localparam logic [7:0]  OPT_RST      = 8'hFF;
  localparam logic [1:0]  INHIBIT_CYC  = 2'h2;
  localparam logic [1:0]  INHIBIT_ZERO = 2'h0;
  typedef enum logic [2:0] {
    TMRC_RUN  = 3'h1,
    TMRC_INH1 = 3'h2,
    TMRC_INH2 = 3'h4
  } tmrc_state_t;
endpackage

//--- logic/tmrc_sync.sv
// two-flop synchroniser with edge pulses for the external clock pin
`timescale 1ns/1ps
module tmrc_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

//--- logic/tmrc_top.sv
// timer/counter with shared prescaler, overflow flag and interrupt request
// Notes on behaviour
// - eight-bit count register, readable and writable by software
// - source select clear: count every instruction cycle without prescaler
// - after a software write, incrementing is held off two cycles
// - source select set: count chosen edge of external clock pin
// - edge select clear means rising edge, set means falling edge
// - prescaler goes to counter when assign bit clear, else watchdog
// - prescaler count is never visible or writable by software
// - prescaler divides by 2 to 256 in powers of two
// - rollover from FFh to 00h sets the overflow flag
// - interrupt request only while overflow enable is set
// - counter stops in sleep, so no rollover raises the flag or interrupt then
`timescale 1ns/1ps
module tmrc_top (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       external_clock_input_pin,
  input  wire logic       clock_source_select,
  input  wire logic       source_edge_select,
  input  wire logic       prescaler_assign,
  input  wire logic [2:0] ps_rate,
  input  wire logic       overflow_irq_enable,
  input  wire logic       sleep,
  input  wire logic       count_wr,
  input  wire logic [7:0] count_wdata,
  input  wire logic       flag_clr,
  input  wire logic       flag_set,
  output logic      [7:0] count_register,
  output logic            overflow_flag,
  output logic            overflow_irq,
  output logic            wdt_tick
);
  logic                 ext_rise;
  logic                 ext_fall;
  logic                 src_tick;
  logic                 ps_tick;
  logic                 cnt_tick;
  logic [7:0]           ps_reg;
  logic [7:0]           ps_next;
  logic [7:0]           cnt_next;
  logic                 wrap;
  tmrc_pkg::tmrc_state_t state_reg;

  tmrc_sync u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (external_clock_input_pin),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  // source pick
  always_comb begin
    if (clock_source_select) begin
      src_tick = source_edge_select ? ext_fall : ext_rise;
    end else begin
      src_tick = 1'b1;
    end
  end

  // prescaler, internal only
  assign ps_next = ps_reg + 8'h01;
  always_comb begin
    ps_tick = src_tick && (ps_next[ps_rate] && !ps_reg[ps_rate]);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ps_reg <= tmrc_pkg::PS_RST;
    end else if (count_wr && !prescaler_assign) begin
      ps_reg <= tmrc_pkg::PS_RST;
    end else if (src_tick && !sleep) begin
      ps_reg <= ps_next;
    end
  end

  assign cnt_tick = prescaler_assign ? src_tick : ps_tick;

  // watchdog side of the prescaler
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_tick <= 1'b0;
    end else begin
      wdt_tick <= prescaler_assign && ps_tick && !sleep;
    end
  end

  // write inhibit sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= tmrc_pkg::TMRC_RUN;
    end else if (count_wr) begin
      state_reg <= tmrc_pkg::TMRC_INH1;
    end else begin
      case (state_reg)
        tmrc_pkg::TMRC_RUN: begin
          state_reg <= tmrc_pkg::TMRC_RUN;
        end
        tmrc_pkg::TMRC_INH1: begin
          state_reg <= tmrc_pkg::TMRC_INH2;
        end
        tmrc_pkg::TMRC_INH2: begin
          state_reg <= tmrc_pkg::TMRC_RUN;
        end
        default: begin
          state_reg <= tmrc_pkg::TMRC_RUN;
        end
      endcase
    end
  end

  assign cnt_next = count_register + 8'h01;
  assign wrap = cnt_tick && !sleep && !count_wr
                && (state_reg == tmrc_pkg::TMRC_RUN)
                && (count_register == tmrc_pkg::CNT_MAX);

  // count register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_register <= tmrc_pkg::CNT_RST;
    end else if (count_wr) begin
      count_register <= count_wdata;
    end else if (cnt_tick && !sleep && state_reg == tmrc_pkg::TMRC_RUN) begin
      count_register <= cnt_next;
    end
  end

  // overflow flag, set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (wrap || flag_set) begin
      overflow_flag <= 1'b1;
    end else if (flag_clr) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_irq_enable && (wrap || flag_set
                      || (overflow_flag && !flag_clr));
    end
  end

  // checks
  property p_write_stall;
    @(posedge mclk) disable iff (!rst_b)
    count_wr ##1 !count_wr [*2] |-> $stable(count_register) ##1 $stable(count_register);
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("count moved in stall");

  property p_wrap_sets_flag;
    @(posedge mclk) disable iff (!rst_b)
    wrap |=> overflow_flag && count_register == 8'h00;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap lost");

  property p_sleep_hold;
    @(posedge mclk) disable iff (!rst_b)
    sleep && !count_wr |=> $stable(count_register);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

  property p_irq_mask;
    @(posedge mclk) disable iff (!rst_b)
    !overflow_irq_enable |=> !overflow_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

  property p_flag_sticky;
    @(posedge mclk) disable iff (!rst_b)
    overflow_flag && !flag_clr |=> overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_timer_inc;
    @(posedge mclk) disable iff (!rst_b)
    rst_b && !clock_source_select && prescaler_assign && !sleep && !count_wr
    && state_reg == tmrc_pkg::TMRC_RUN
    |=> count_register == $past(count_register) + 8'h01;
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("timer missed");

  property p_write_load;
    @(posedge mclk) disable iff (!rst_b)
    count_wr |=> count_register == $past(count_wdata);
  endproperty
  a_write_load: assert property (p_write_load) else $error("write lost");

  property p_ext_needs_edge;
    @(posedge mclk) disable iff (!rst_b)
    clock_source_select && !ext_rise && !ext_fall && !count_wr
    |=> $stable(count_register);
  endproperty
  a_ext_needs_edge: assert property (p_ext_needs_edge) else $error("count w/o edge");

  property p_ps_div2;
    @(posedge mclk) disable iff (!rst_b)
    src_tick |-> ps_tick == (({1'b0, ps_reg} & ((9'h002 << ps_rate) - 9'h001))
                             == (9'h001 << ps_rate) - 9'h001);
  endproperty
  a_ps_div2: assert property (p_ps_div2) else $error("prescale tick bad");

  property p_irq_follows;
    @(posedge mclk) disable iff (!rst_b)
    overflow_irq_enable && overflow_flag && !flag_clr |=> overflow_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

  property p_inhibit_ends;
    @(posedge mclk) disable iff (!rst_b)
    count_wr ##1 !count_wr [*2] |=> state_reg == tmrc_pkg::TMRC_RUN;
  endproperty
  a_inhibit_ends: assert property (p_inhibit_ends) else $error("stall too long");

  c_wrap: cover property (@(posedge mclk) disable iff (!rst_b) wrap);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_b) overflow_irq);
  c_ext: cover property (@(posedge mclk) disable iff (!rst_b) clock_source_select && ext_fall);
  c_wr: cover property (@(posedge mclk) disable iff (!rst_b) count_wr ##3 !count_wr);
endmodule

//--- tb/tmrc_ext_src.sv
// external clock source driving the counter input pin
`timescale 1ns/1ps
module tmrc_ext_src (
  output logic pin
);
  initial pin = 1'b0;
  // one held level change, stands still afterwards
  task automatic level(input logic v);
    pin = v;
  endtask
  // whole low-high-low pulses, each phase longer than the synchroniser
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      #(half) pin = 1'b1;
      #(half) pin = 1'b0;
    end
  endtask
endmodule

//--- tb/test_tmrc_top.sv
// self-checking bench for the timer/counter with prescaler
`timescale 1ns/1ps
module test_tmrc_top;
  logic       mclk  = 1'b0;
  logic       rst_b = 1'b0;
  logic       cs    = 1'b0;
  logic       se    = 1'b0;
  logic       pa    = 1'b1;
  logic       ie    = 1'b0;
  logic       slp   = 1'b0;
  logic       wr    = 1'b0;
  logic       fclr  = 1'b0;
  logic       fset  = 1'b0;
  logic [2:0] rate  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       pin;
  logic [7:0] cnt;
  logic       flag;
  logic       irq;
  logic       wdt;
  logic [7:0] v;
  int         n_mismatch = 0;
  int         compares   = 0;
  int         cyc        = 0;
  int         t;

  tmrc_ext_src tmrc_ext_src_inst (.pin(pin));
  tmrc_top tmrc_top_inst (.mclk(mclk), .rst_b(rst_b), .external_clock_input_pin(pin),
    .clock_source_select(cs), .source_edge_select(se), .prescaler_assign(pa),
    .ps_rate(rate), .overflow_irq_enable(ie), .sleep(slp), .count_wr(wr),
    .count_wdata(wdata), .flag_clr(fclr), .flag_set(fset), .count_register(cnt),
    .overflow_flag(flag), .overflow_irq(irq), .wdt_tick(wdt));

  always #2.5 mclk = ~mclk;

  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wrc(input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
    #1;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    ie    <= 1'b1;
    wrc(8'hFE);
    chk("count", 8'hFE, cnt);
    tk(2);
    chk("count", 8'hFE, cnt);
    tk(1);
    chk("count", 8'hFF, cnt);
    tk(1);
    chk("count", 8'h00, cnt);
    chk("flag", 8'h01, {7'h00, flag});
    tk(1);
    chk("irq", 8'h01, {7'h00, irq});
    chk("count", 8'h01, cnt);
    @(posedge mclk);
    ie <= 1'b0;
    tk(3);
    chk("irq", 8'h00, {7'h00, irq});
    chk("flag", 8'h01, {7'h00, flag});
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    tk(1);
    chk("flag", 8'h00, {7'h00, flag});
    @(posedge mclk);
    fset <= 1'b1;
    fclr <= 1'b1;
    @(posedge mclk);
    fset <= 1'b0;
    fclr <= 1'b0;
    tk(1);
    chk("flag", 8'h01, {7'h00, flag});
    chk("irq", 8'h00, {7'h00, irq});
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    tk(1);
    chk("flag", 8'h00, {7'h00, flag});
    wrc(8'h10);
    @(posedge mclk);
    slp <= 1'b1;
    tk(20);
    chk("count", 8'h10, cnt);
    @(posedge mclk);
    slp <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      pa   <= 1'b0;
      rate <= k[2:0];
      wrc(8'h00);
      for (t = 0; t < 600 && cnt !== 8'h01; t++) tk(1);
      for (t = 0; t < 600 && cnt !== 8'h02; t++) tk(1);
      chk("ratio", 8'((2 << k) - 1), 8'(t - 1));
    end
    v = 8'h00;
    repeat (20) begin
      tk(1);
      v[0] = v[0] | wdt;
    end
    chk("wdt", 8'h00, v);
    @(posedge mclk);
    pa   <= 1'b1;
    rate <= 3'h0;
    repeat (20) begin
      tk(1);
      v[0] = v[0] | wdt;
    end
    chk("wdt", 8'h01, v);
    @(posedge mclk);
    cs <= 1'b1;
    wrc(8'h00);
    tk(4);
    tmrc_ext_src_inst.pulses(5, 15);
    tk(6);
    chk("count", 8'h05, cnt);
    tmrc_ext_src_inst.level(1'b1);
    tk(6);
    chk("count", 8'h06, cnt);
    @(posedge mclk);
    se <= 1'b1;
    tk(2);
    tmrc_ext_src_inst.level(1'b0);
    tk(6);
    chk("count", 8'h07, cnt);
    tmrc_ext_src_inst.level(1'b1);
    tk(6);
    chk("count", 8'h07, cnt);
    finish_test();
  end
endmodule
